// [src/servo_status_pkg.sv]
// Constants, register map and carrier types for the servo status output logic.
package servo_status_pkg;
    // Clock and timing.
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int POWERUP_MS = 3000;
    localparam int POWERUP_CYCLES = POWERUP_MS * MS_CYCLES;
    // Speed-reached band is set * 0.05 + 20 r/min, i.e. set / 20 + 20.
    localparam int SPD_BAND_DIV = 20;
    localparam int SPD_BAND_OFS = 20;
    localparam logic [15:0] SPD_ALWAYS_MAX = 16'h0014;
    // Register indices on the plain register port.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_INP_RANGE = 8'h01;
    localparam logic [7:0] REG_FWD_TL = 8'h02;
    localparam logic [7:0] REG_REV_TL = 8'h03;
    localparam logic [7:0] REG_ZSP_THR = 8'h04;
    localparam logic [7:0] REG_BRK_DLY = 8'h05;
    localparam logic [7:0] REG_STATUS = 8'h06;
    localparam logic [7:0] REG_SPD_LIM0 = 8'h08;
    localparam int NUM_SPD_LIM = 7;
    // Control register fields.
    localparam int CTRL_CODE_EN = 0;
    localparam int CTRL_WARN_FAULT = 1;
    localparam int CTRL_RT_EN = 2;
    localparam int CTRL_PIN0_LSB = 4;
    localparam int CTRL_PIN1_LSB = 6;
    localparam int CTRL_PIN2_LSB = 8;
    // Shared pin assignment codes.
    localparam logic [1:0] PIN_NATIVE = 2'h0;
    localparam logic [1:0] PIN_BRAKE = 2'h1;
    localparam logic [1:0] PIN_FAULT = 2'h2;
    localparam logic [1:0] PIN_WARN = 2'h3;
    // Reset values.
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] INP_RANGE_RST = 16'h0064;
    localparam logic [15:0] TL_RST = 16'h03E8;
    localparam logic [15:0] ZSP_THR_RST = 16'h0032;
    localparam logic [15:0] BRK_DLY_RST = 16'h0000;
    localparam logic [15:0] SPD_LIM_RST = 16'h0BB8;
    // Parameter error alarm number and the code it shows on the shared pins.
    localparam logic [7:0] PARAM_ERR_NUM = 8'h25;
    localparam logic [2:0] PARAM_ERR_ACD = 3'h1;

    // Motor feedback from the control loop.
    typedef struct packed {
        logic signed [15:0] motor_speed;
        logic signed [15:0] set_speed;
        logic signed [15:0] torque;
        logic [15:0] droop_abs;
    } drive_fb_t;

    // Analog limit inputs and their enables.
    typedef struct packed {
        logic [15:0] speed_lim;
        logic speed_lim_en;
        logic [15:0] torque_lim;
        logic torque_lim_en;
    } analog_lim_t;

    // Discrete status flags, also the low bits of the status register.
    typedef struct packed {
        logic powerup_done;
        logic param_err;
        logic ride_through;
        logic gain_switch;
        logic warning;
        logic brake;
        logic zero_speed;
        logic torque_lim;
        logic speed_lim;
        logic speed_reached;
        logic in_position;
        logic ready;
        logic fault_clear;
    } status_t;
endpackage : servo_status_pkg

// [src/servo_status_output.sv]
// Discrete status output logic of the servo drive.
// Operation
// - Fault-clear output drops whenever any alarm is present.
// - Without alarm, fault-clear rises 2.5 s to 3.5 s after power-on.
// - With warning-on-fault mode set, warnings also drop fault-clear.
// - Ready rises once servo-on is given and the drive is ready.
// - In-position is high while droop pulses lie within the set range.
// - In-position stays low while servo is off.
// - Speed reached when within set speed * 0.05 + 20 r/min of set speed.
// - Set speed of 20 r/min or less keeps speed reached high.
// - Speed reached stays low with servo off or both start inputs off.
// - Speed limiting when speed meets internal limit one to seven or analog limit.
// - Speed limiting drops whenever servo-on turns off.
// - Torque limiting when torque meets forward, reverse or analog limit.
// - Zero speed high while speed is at or below the threshold, default 50.
// - Brake interlock drops at once on servo off or alarm; base hold on servo off lasts the brake delay.
// - Warning output is high while any warning is active.
// - Without warning, warning output drops 2.5 s to 3.5 s after power-on.
// - Fault code mode with alarm drives the alarm code on the shared pins.
// - Without alarm the shared pins carry their ordinary assigned signals.
// - Fault code mode with brake or fault-clear on a shared pin raises alarm 37.
// - Gain switch indication is high while the alternate gain set is used.
// - Ride-through indication is high when enabled and ride-through is active.
`timescale 1ns/1ns
module servo_status_output
    import servo_status_pkg::*;
#(
    parameter int POWERUP_CNT = POWERUP_CYCLES,
    parameter int MS_CNT = MS_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic servo_on_in,
    input wire logic fwd_start_in,
    input wire logic rev_start_in,
    input wire logic drive_ready_in,
    input wire logic alarm_in,
    input wire logic [2:0] alarm_code_in,
    input wire logic warning_in,
    input wire logic gain_select_in,
    input wire logic ride_through_in,
    input wire logic [2:0] speed_lim_sel_in,
    input wire drive_fb_t fb_in,
    input wire analog_lim_t analog_in,
    output logic fault_clear_out,
    output logic ready_out,
    output logic in_position_out,
    output logic speed_reached_out,
    output logic speed_limiting_out,
    output logic torque_limiting_out,
    output logic zero_speed_out,
    output logic brake_interlock_out,
    output logic base_hold_out,
    output logic warning_out,
    output logic gain_switch_active_out,
    output logic ride_through_active_out,
    output logic parameter_error_alarm_out,
    output logic [2:0] shared_pins_out
);
    typedef enum logic [1:0] {BRK_ENGAGED, BRK_RELEASED, BRK_HOLDOFF} brake_state_t;

    logic [15:0] ctrl;
    logic [15:0] inp_range;
    logic [15:0] fwd_tl;
    logic [15:0] rev_tl;
    logic [15:0] zsp_thr;
    logic [15:0] brk_dly;
    logic [15:0] spd_lim [NUM_SPD_LIM];
    logic [31:0] pwr_cnt;
    logic powerup_done;
    logic [31:0] ms_cnt;
    logic [15:0] hold_ms;
    brake_state_t brk_state;
    status_t next_st;
    logic [2:0] next_pins;
    logic alarm_any;
    logic param_err;
    logic [15:0] spd_mag;
    logic [15:0] set_mag;
    logic [15:0] trq_mag;
    logic [16:0] spd_err;
    logic [15:0] act_spd_lim;
    logic [15:0] act_trq_lim;
    logic [1:0] pin_sel [3];
    logic [2:0] pin_native;

    // Magnitude of a signed 16-bit value; -32768 maps to 0x8000.
    function automatic logic [15:0] mag(input logic signed [15:0] v);
        mag = v[15] ? 16'(-v) : 16'(v);
    endfunction : mag

    // Register writes from software.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= CTRL_RST;
            inp_range <= INP_RANGE_RST;
            fwd_tl <= TL_RST;
            rev_tl <= TL_RST;
            zsp_thr <= ZSP_THR_RST;
            brk_dly <= BRK_DLY_RST;
            for (int i = 0; i < NUM_SPD_LIM; i++) begin
                spd_lim[i] <= SPD_LIM_RST;
            end
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                REG_CTRL: ctrl <= reg_wdata_in;
                REG_INP_RANGE: inp_range <= reg_wdata_in;
                REG_FWD_TL: fwd_tl <= reg_wdata_in;
                REG_REV_TL: rev_tl <= reg_wdata_in;
                REG_ZSP_THR: zsp_thr <= reg_wdata_in;
                REG_BRK_DLY: brk_dly <= reg_wdata_in;
                default: begin
                    for (int i = 0; i < NUM_SPD_LIM; i++) begin
                        if (reg_addr_in == REG_SPD_LIM0 + 8'(i)) begin
                            spd_lim[i] <= reg_wdata_in;
                        end
                    end
                end
            endcase
        end
    end

    // Read data appears in the cycle after the read strobe; unmapped reads give zero.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= 16'h0000;
            case (reg_addr_in)
                REG_CTRL: reg_rdata_out <= ctrl;
                REG_INP_RANGE: reg_rdata_out <= inp_range;
                REG_FWD_TL: reg_rdata_out <= fwd_tl;
                REG_REV_TL: reg_rdata_out <= rev_tl;
                REG_ZSP_THR: reg_rdata_out <= zsp_thr;
                REG_BRK_DLY: reg_rdata_out <= brk_dly;
                REG_STATUS: reg_rdata_out <= {3'h0, powerup_done, param_err, ride_through_active_out,
                    gain_switch_active_out, warning_out, brake_interlock_out, zero_speed_out,
                    torque_limiting_out, speed_limiting_out, speed_reached_out, in_position_out,
                    ready_out, fault_clear_out};
                default: begin
                    for (int i = 0; i < NUM_SPD_LIM; i++) begin
                        if (reg_addr_in == REG_SPD_LIM0 + 8'(i)) begin
                            reg_rdata_out <= spd_lim[i];
                        end
                    end
                end
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    // Power-on delay; fault-clear, ready, brake interlock and warning keep their defaults until it expires.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwr_cnt <= 32'h0000_0000;
            powerup_done <= 1'b0;
        end else if (!powerup_done) begin
            pwr_cnt <= pwr_cnt + 32'h0000_0001;
            powerup_done <= (pwr_cnt >= 32'(POWERUP_CNT - 1));
        end
    end

    // Shared pin selections and the configuration conflict check.
    assign pin_sel[0] = ctrl[CTRL_PIN0_LSB +: 2];
    assign pin_sel[1] = ctrl[CTRL_PIN1_LSB +: 2];
    assign pin_sel[2] = ctrl[CTRL_PIN2_LSB +: 2];
    always_comb begin
        param_err = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (pin_sel[i] == PIN_BRAKE || pin_sel[i] == PIN_FAULT) begin
                param_err = ctrl[CTRL_CODE_EN];
            end
        end
    end
    assign alarm_any = alarm_in | param_err;

    // Magnitudes and active limits for the comparisons.
    assign spd_mag = mag(fb_in.motor_speed);
    assign set_mag = mag(fb_in.set_speed);
    assign trq_mag = mag(fb_in.torque);
    assign spd_err = (17'(fb_in.motor_speed) - 17'(fb_in.set_speed));
    always_comb begin
        act_spd_lim = spd_lim[NUM_SPD_LIM - 1];
        if (speed_lim_sel_in < 3'(NUM_SPD_LIM)) begin
            act_spd_lim = spd_lim[speed_lim_sel_in];
        end
        if (analog_in.speed_lim_en) begin
            act_spd_lim = analog_in.speed_lim;
        end
        act_trq_lim = fb_in.torque[15] ? rev_tl : fwd_tl;
        if (analog_in.torque_lim_en) begin
            act_trq_lim = analog_in.torque_lim;
        end
    end

    // Next value of every status flag, evaluated each cycle.
    always_comb begin
        logic [16:0] err_mag;
        logic [23:0] err_x;
        logic [23:0] band;
        err_mag = spd_err[16] ? 17'(-spd_err) : spd_err;
        err_x = 24'(err_mag) * 24'(SPD_BAND_DIV);
        band = 24'(set_mag) + 24'(SPD_BAND_DIV * SPD_BAND_OFS);
        next_st = '0;
        next_st.powerup_done = powerup_done;
        next_st.param_err = param_err;
        next_st.fault_clear = powerup_done && !alarm_any
            && !(ctrl[CTRL_WARN_FAULT] && warning_in);
        next_st.ready = servo_on_in && drive_ready_in && !alarm_any && powerup_done;
        next_st.in_position = servo_on_in && (fb_in.droop_abs <= inp_range);
        next_st.speed_reached = servo_on_in && (fwd_start_in || rev_start_in)
            && ((set_mag <= SPD_ALWAYS_MAX) || (err_x <= band));
        next_st.speed_lim = servo_on_in && (spd_mag >= act_spd_lim);
        next_st.torque_lim = trq_mag >= act_trq_lim;
        next_st.zero_speed = spd_mag <= zsp_thr;
        next_st.warning = !powerup_done || warning_in;
        next_st.gain_switch = gain_select_in;
        next_st.ride_through = ctrl[CTRL_RT_EN] && ride_through_in;
        next_st.brake = servo_on_in && !alarm_any && powerup_done;
    end

    // Shared pins carry the fault code during an alarm, else their assigned signals.
    assign pin_native = {next_st.ready, next_st.zero_speed, next_st.in_position};
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            case (pin_sel[i])
                PIN_BRAKE: next_pins[i] = next_st.brake;
                PIN_FAULT: next_pins[i] = next_st.fault_clear;
                PIN_WARN: next_pins[i] = next_st.warning;
                default: next_pins[i] = pin_native[i];
            endcase
        end
        if (ctrl[CTRL_CODE_EN] && alarm_any) begin
            next_pins = alarm_in ? alarm_code_in : PARAM_ERR_ACD;
        end
    end

    // Registered status outputs, so none glitches between evaluations.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_clear_out <= 1'b0;
            ready_out <= 1'b0;
            in_position_out <= 1'b0;
            speed_reached_out <= 1'b0;
            speed_limiting_out <= 1'b0;
            torque_limiting_out <= 1'b0;
            zero_speed_out <= 1'b0;
            warning_out <= 1'b1;
            gain_switch_active_out <= 1'b0;
            ride_through_active_out <= 1'b0;
            parameter_error_alarm_out <= 1'b0;
            shared_pins_out <= 3'h0;
        end else begin
            fault_clear_out <= next_st.fault_clear;
            ready_out <= next_st.ready;
            in_position_out <= next_st.in_position;
            speed_reached_out <= next_st.speed_reached;
            speed_limiting_out <= next_st.speed_lim;
            torque_limiting_out <= next_st.torque_lim;
            zero_speed_out <= next_st.zero_speed;
            warning_out <= next_st.warning;
            gain_switch_active_out <= next_st.gain_switch;
            ride_through_active_out <= next_st.ride_through;
            parameter_error_alarm_out <= next_st.param_err;
            shared_pins_out <= next_pins;
        end
    end

    // Brake sequencing: the brake engages at once, and on a plain servo-off the
    // motor base stays energised for the brake delay so the load cannot drop.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            brk_state <= BRK_ENGAGED;
            brake_interlock_out <= 1'b0;
            base_hold_out <= 1'b0;
            ms_cnt <= 32'h0000_0000;
            hold_ms <= 16'h0000;
        end else begin
            case (brk_state)
                BRK_ENGAGED: begin
                    base_hold_out <= 1'b0;
                    if (next_st.brake) begin
                        brk_state <= BRK_RELEASED;
                        brake_interlock_out <= 1'b1;
                    end
                end
                BRK_RELEASED: begin
                    if (!next_st.brake) begin
                        brake_interlock_out <= 1'b0;
                        ms_cnt <= 32'h0000_0000;
                        hold_ms <= brk_dly;
                        base_hold_out <= !alarm_any && (brk_dly != 16'h0000);
                        brk_state <= (!alarm_any && brk_dly != 16'h0000) ? BRK_HOLDOFF : BRK_ENGAGED;
                    end
                end
                BRK_HOLDOFF: begin
                    if (alarm_any || hold_ms == 16'h0000) begin
                        base_hold_out <= 1'b0;
                        brk_state <= BRK_ENGAGED;
                    end else if (ms_cnt >= 32'(MS_CNT - 1)) begin
                        ms_cnt <= 32'h0000_0000;
                        hold_ms <= hold_ms - 16'h0001;
                    end else begin
                        ms_cnt <= ms_cnt + 32'h0000_0001;
                    end
                end
                default: begin
                    brk_state <= BRK_ENGAGED;
                    brake_interlock_out <= 1'b0;
                    base_hold_out <= 1'b0;
                end
            endcase
        end
    end

    // Checks on the status outputs.
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    fault_alarm_a: assert property (alarm_any |=> !fault_clear_out)
        else $error("fault clear high during alarm");
    fault_early_a: assert property (!powerup_done |=> !fault_clear_out && warning_out)
        else $error("fault clear or warning left default before power-up delay");
    fault_rise_a: assert property ($rose(powerup_done) && !alarm_any && !warning_in |=> fault_clear_out)
        else $error("fault clear not raised after power-up delay");
    fault_warn_a: assert property (ctrl[CTRL_WARN_FAULT] && warning_in |=> !fault_clear_out)
        else $error("warning did not drop fault clear");
    ready_on_a: assert property (ready_out |-> $past(servo_on_in) && $past(drive_ready_in))
        else $error("ready without servo on");
    inpos_off_a: assert property (!servo_on_in |=> !in_position_out)
        else $error("in position with servo off");
    reach_gate_a: assert property (!servo_on_in || !(fwd_start_in || rev_start_in) |=> !speed_reached_out)
        else $error("speed reached while gated off");
    reach_low_a: assert property (servo_on_in && fwd_start_in && set_mag <= SPD_ALWAYS_MAX |=> speed_reached_out)
        else $error("speed reached low for low set speed");
    limit_off_a: assert property (!servo_on_in |=> !speed_limiting_out)
        else $error("speed limiting with servo off");
    zero_speed_a: assert property (spd_mag <= zsp_thr |=> zero_speed_out)
        else $error("zero speed missed");
    brake_drop_a: assert property (!servo_on_in || alarm_any |=> !brake_interlock_out)
        else $error("brake interlock held through servo off or alarm");
    warn_out_a: assert property (powerup_done && warning_in |=> warning_out [*1])
        else $error("warning not shown");
    code_out_a: assert property (ctrl[CTRL_CODE_EN] && alarm_in |=> shared_pins_out == $past(alarm_code_in))
        else $error("fault code not on shared pins");
    param_err_a: assert property (ctrl[CTRL_CODE_EN] && pin_sel[0] == PIN_FAULT |=> parameter_error_alarm_out)
        else $error("parameter error not raised");
    inpos_on_a: assert property (servo_on_in && fb_in.droop_abs <= inp_range |=> in_position_out)
        else $error("in position missed inside range");
    torque_on_a: assert property (trq_mag >= act_trq_lim |=> torque_limiting_out)
        else $error("torque limiting missed");
    ride_gate_a: assert property (!ctrl[CTRL_RT_EN] |=> !ride_through_active_out)
        else $error("ride-through shown while disabled");

    powerup_c: cover property ($rose(fault_clear_out));
    code_c: cover property (ctrl[CTRL_CODE_EN] && alarm_in ##1 shared_pins_out != 3'h0);
    hold_c: cover property (base_hold_out ##1 !base_hold_out);
    reach_c: cover property ($rose(speed_reached_out));
    pin_sel_c: cover property (!ctrl[CTRL_CODE_EN] && pin_sel[2] == PIN_WARN ##1 shared_pins_out[2]);
endmodule : servo_status_output

// [sim/host_status_reader.sv]
// Host controller model that requests gain switching and samples the gain indication.
`timescale 1ns/1ns
module host_status_reader (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic gain_req_in,
    input wire logic gain_switch_active_in,
    output logic gain_select_out,
    output logic gain_seen_out
);
    // The host changes its request only just after an edge, like a registered controller output.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gain_select_out <= 1'b0;
            gain_seen_out <= 1'b0;
        end else begin
            gain_select_out <= gain_req_in;
            gain_seen_out <= gain_switch_active_in;
        end
    end
endmodule : host_status_reader

// [sim/tb_servo_status_output_logic.sv]
// Self-checking testbench for the servo status output logic.
`timescale 1ns/1ns
module tb_servo_status_output_logic;
    import servo_status_pkg::*;
    localparam int PU = 20;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out;
    logic servo_on_in = 1'b0, fwd_start_in = 1'b0, rev_start_in = 1'b0, drive_ready_in = 1'b0;
    logic alarm_in = 1'b0, warning_in = 1'b0, ride_through_in = 1'b0, gain_req = 1'b0, gain_select, gain_seen;
    logic [2:0] alarm_code_in = 3'h0, speed_lim_sel_in = 3'h0, shared_pins_out;
    drive_fb_t fb_in = '0;
    analog_lim_t analog_in = '0;
    logic fault_clear_out, ready_out, in_position_out, speed_reached_out, speed_limiting_out;
    logic torque_limiting_out, zero_speed_out, brake_interlock_out, base_hold_out, warning_out;
    logic gain_switch_active_out, ride_through_active_out, parameter_error_alarm_out;
    int mismatches = 0, checked = 0;

    // Short count values keep the power-up and brake waits brief.
    servo_status_output #(.POWERUP_CNT(PU), .MS_CNT(4)) dut_u (
        .clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .servo_on_in, .fwd_start_in, .rev_start_in, .drive_ready_in, .alarm_in, .alarm_code_in, .warning_in,
        .gain_select_in(gain_select), .ride_through_in, .speed_lim_sel_in, .fb_in, .analog_in,
        .fault_clear_out, .ready_out, .in_position_out, .speed_reached_out, .speed_limiting_out,
        .torque_limiting_out, .zero_speed_out, .brake_interlock_out, .base_hold_out, .warning_out,
        .gain_switch_active_out, .ride_through_active_out, .parameter_error_alarm_out, .shared_pins_out);

    // The host model drives the gain select input.
    host_status_reader host_u (.clk_sys_in, .rst_n_in, .gain_req_in(gain_req),
        .gain_switch_active_in(gain_switch_active_out), .gain_select_out(gain_select), .gain_seen_out(gain_seen));

    // Free-running 50 MHz clock.
    always #10 clk_sys_in = ~clk_sys_in;

    task automatic complete_run();
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic check_bit(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check_bit

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check_word

    // Lets registered outputs catch up with inputs changed at the last edge.
    task automatic settle();
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask : settle

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        settle();
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : reg_read

    // Arguments are set speed, motor speed, torque and droop, in that order.
    task automatic apply_fb(input logic [15:0] s, m, t, dr);
        @(posedge clk_sys_in);
        fb_in <= '{m, s, t, dr};
        settle();
    endtask : apply_fb

    task automatic powerup_check();
        int n;
        n = 0;
        #1;
        check_bit(warning_out, 1'b1, "warning default");
        check_bit(fault_clear_out, 1'b0, "fault default");
        while (fault_clear_out !== 1'b1 && n < 2 * PU) begin
            @(posedge clk_sys_in);
            #1 n++;
        end
        check_bit(n >= PU * 5 / 6 && n <= PU * 7 / 6 + 2, 1'b1, "power-up delay");
        check_bit(warning_out, 1'b0, "warning release");
        if (n >= 2 * PU) begin
            complete_run();
        end
    endtask : powerup_check

    task automatic reg_defaults();
        logic [7:0] a[6] = '{REG_INP_RANGE, REG_FWD_TL, REG_REV_TL, REG_ZSP_THR, REG_SPD_LIM0, 8'h07};
        logic [15:0] e[6] = '{16'h0064, 16'h03E8, 16'h03E8, 16'h0032, 16'h0BB8, 16'h0000};
        logic [15:0] d;
        for (int i = 0; i < 6; i++) begin
            reg_read(a[i], d);
            check_word(d, e[i], "register default");
        end
    endtask : reg_defaults

    task automatic alarm_check();
        @(posedge clk_sys_in);
        servo_on_in <= 1'b1;
        drive_ready_in <= 1'b1;
        apply_fb(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        check_bit(ready_out & brake_interlock_out, 1'b1, "ready");
        reg_write(REG_CTRL, 16'h0001);
        alarm_code_in <= 3'h5;
        alarm_in <= 1'b1;
        settle();
        check_bit(fault_clear_out | brake_interlock_out, 1'b0, "alarm");
        check_word({13'h0000, shared_pins_out}, 16'h0005, "code pins");
        @(posedge clk_sys_in);
        alarm_in <= 1'b0;
        settle();
        check_word({13'h0000, shared_pins_out}, 16'h0007, "native pins");
        reg_write(REG_CTRL, 16'h0121);
        check_bit(parameter_error_alarm_out & ~fault_clear_out, 1'b1, "param error");
        reg_write(REG_CTRL, 16'h0002);
        check_bit(parameter_error_alarm_out, 1'b0, "param clear");
        warning_in <= 1'b1;
        settle();
        check_bit(warning_out & ~fault_clear_out, 1'b1, "warning fault");
        reg_write(REG_CTRL, 16'h0004);
        check_bit(fault_clear_out, 1'b1, "warning only");
        ride_through_in <= 1'b1;
        gain_req <= 1'b1;
        settle();
        check_bit(ride_through_active_out & gain_switch_active_out, 1'b1, "ride gain");
        reg_write(REG_CTRL, 16'h0000);
        check_bit(ride_through_active_out, 1'b0, "ride off");
    endtask : alarm_check

    task automatic motion_check();
        logic [15:0] d;
        @(posedge clk_sys_in);
        fwd_start_in <= 1'b1;
        apply_fb(16'd1000, 16'd1070, 16'd1000, 16'd100);
        check_bit(speed_reached_out & torque_limiting_out & in_position_out, 1'b1, "band edge");
        apply_fb(16'd1000, 16'd1071, 16'hFC18, 16'd101);
        check_bit(speed_reached_out | in_position_out | ~torque_limiting_out, 1'b0, "band out");
        apply_fb(16'd20, 16'd50, 16'd999, 16'd0);
        check_bit(speed_reached_out & zero_speed_out & ~torque_limiting_out, 1'b1, "low set");
        apply_fb(16'd20, 16'd51, 16'd0, 16'd0);
        check_bit(zero_speed_out, 1'b0, "zero speed");
        fwd_start_in <= 1'b0;
        apply_fb(16'd0, 16'd3000, 16'd0, 16'd0);
        check_bit(speed_reached_out | ~speed_limiting_out, 1'b0, "limit one");
        analog_in <= '{16'd500, 1'b1, 16'd0, 1'b1};
        apply_fb(16'd0, 16'd400, 16'd0, 16'd0);
        check_bit(speed_limiting_out, 1'b0, "below analog");
        apply_fb(16'd0, 16'd500, 16'd0, 16'd0);
        check_bit(speed_limiting_out, 1'b1, "analog limit");
        reg_write(REG_BRK_DLY, 16'h0002);
        reg_write(REG_CTRL, 16'h0390);
        servo_on_in <= 1'b0;
        settle();
        check_bit(speed_limiting_out | in_position_out | brake_interlock_out, 1'b0, "servo off");
        check_bit(base_hold_out, 1'b1, "base hold");
        check_word({13'h0000, shared_pins_out}, 16'h0006, "pin select");
        repeat (9) @(posedge clk_sys_in);
        #1 check_bit(base_hold_out, 1'b0, "hold end");
        reg_read(REG_STATUS, d);
        check_word(d, 16'h1321, "status word");
        check_bit(gain_seen, 1'b1, "host gain seen");
    endtask : motion_check

    // Reset for ten cycles, then run every scenario in turn.
    initial begin
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        powerup_check();
        reg_defaults();
        alarm_check();
        motion_check();
        complete_run();
    end
endmodule : tb_servo_status_output_logic
